// >>> rtl/ufa_pkg.sv
// shared constants and types for the frame error and address match block
package ufa_pkg;
  // register word indices; byte address is four times the index
  localparam logic [7:0] SERIAL_CONTROL_IDX = 8'h98;
  localparam logic [7:0] RX_BUFFER_IDX = 8'h99;
  localparam logic [7:0] POWER_CONTROL_IDX = 8'h87;
  localparam logic [7:0] SLAVE_ADDRESS_IDX = 8'hA9;
  localparam logic [7:0] SLAVE_ADDRESS_MASK_IDX = 8'hB9;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'hC0;
  localparam logic [7:0] IRQ_MASK_IDX = 8'hC1;
  localparam logic [7:0] BAUD_DIV_IDX = 8'hC2;
  // serial control bit positions
  localparam int SC_MODE_HI = 7;
  localparam int SC_MODE_LO = 6;
  localparam int SC_MP_EN = 5;
  localparam int SC_RX_EN = 4;
  localparam int SC_RX_NINTH = 2;
  localparam int SC_RX_DONE = 0;
  // power control bit that picks the error view
  localparam int PC_VIEW = 6;
  // interrupt status bit positions
  localparam int IRQ_RX = 0;
  localparam int IRQ_FE = 1;
  localparam int IRQ_W = 2;
  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] BAUD_DIV_RST = 16'h001A;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // sixteenth-bit slices where the line is voted, then last data bit numbers
  localparam logic [3:0] SLICE_A = 4'h7;
  localparam logic [3:0] SLICE_B = 4'h8;
  localparam logic [3:0] SLICE_C = 4'h9;
  localparam logic [3:0] LAST_DATA_8 = 4'h7;
  localparam logic [3:0] LAST_DATA_9 = 4'h8;
  // ahb transfer type bit that marks an active transfer
  localparam int HTRANS_ACTIVE = 1;
  typedef enum logic [1:0] {
    UFA_IDLE,
    UFA_START,
    UFA_DATA,
    UFA_STOP
  } ufa_rx_state_t;
endpackage

// >>> rtl/ufa_match.sv
// given and broadcast address comparison
`timescale 1ns/1ns
module ufa_match
  import ufa_pkg::*;
(
  input wire logic [7:0] i_byte,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_mask,
  output logic o_match
);
  logic [7:0] bcast_care; // broadcast positions that must be one
  logic given_hit;
  logic bcast_hit;
  // the given test uses only masked positions; the broadcast test uses positions set in address or mask
  always_comb begin
    bcast_care = i_addr | i_mask;
    given_hit = (i_byte & i_mask) == (i_addr & i_mask);
    bcast_hit = (i_byte & bcast_care) == bcast_care;
    o_match = given_hit | bcast_hit;
  end
endmodule

// >>> rtl/ufa_rx.sv
// oversampling receiver: start check, majority vote, 8 or 9 data bits
`timescale 1ns/1ns
module ufa_rx
  import ufa_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire logic i_nine,
  input wire logic [15:0] i_div,
  input wire logic i_rxd,
  output logic o_done,
  output logic [7:0] o_data,
  output logic o_ninth,
  output logic o_stop
);
  ufa_rx_state_t state_q, state_d;
  logic [15:0] div_q, div_d; // 16x tick divider
  logic [3:0] slice_q, slice_d; // slice within the bit
  logic [1:0] votes_q, votes_d; // ones seen at first two samples
  logic [3:0] bitno_q, bitno_d;
  logic [8:0] shift_q, shift_d;
  logic prev_q, prev_d; // line one cycle ago
  logic done_q, done_d;
  logic [7:0] data_q, data_d;
  logic ninth_q, ninth_d;
  logic stop_q, stop_d;
  logic tick;
  logic bitv;
  // frame sequencing
  always_comb begin
    state_d = state_q;
    div_d = div_q;
    slice_d = slice_q;
    votes_d = votes_q;
    bitno_d = bitno_q;
    shift_d = shift_q;
    prev_d = i_rxd;
    done_d = 1'b0;
    data_d = data_q;
    ninth_d = ninth_q;
    stop_d = stop_q;
    tick = (div_q == i_div);
    bitv = (2'(votes_q) + 2'(i_rxd)) >= 2'h2;
    if (!i_enable) begin
      state_d = UFA_IDLE;
    end else if (state_q == UFA_IDLE) begin
      // falling edge realigns the slice counter
      if (prev_q && !i_rxd) begin
        state_d = UFA_START;
        div_d = 16'h0000;
        slice_d = 4'h0;
        votes_d = 2'h0;
      end
    end else if (tick) begin
      div_d = 16'h0000;
      slice_d = slice_q + 4'h1;
      if ((slice_q == SLICE_A || slice_q == SLICE_B) && i_rxd) begin
        votes_d = votes_q + 2'h1;
      end
      if (slice_q == SLICE_C) begin
        votes_d = 2'h0;
        case (state_q)
          UFA_START: begin
            // a one here is a false start
            state_d = bitv ? UFA_IDLE : UFA_DATA;
            bitno_d = 4'h0;
          end
          UFA_DATA: begin
            shift_d = {bitv, shift_q[8:1]};
            bitno_d = bitno_q + 4'h1;
            if (bitno_q == (i_nine ? LAST_DATA_9 : LAST_DATA_8)) begin
              state_d = UFA_STOP;
            end
          end
          UFA_STOP: begin
            // back to hunting after mid stop bit
            state_d = UFA_IDLE;
            done_d = 1'b1;
            stop_d = bitv;
            data_d = i_nine ? shift_q[7:0] : shift_q[8:1];
            ninth_d = shift_q[8];
          end
          default: state_d = UFA_IDLE;
        endcase
      end
    end else begin
      div_d = div_q + 16'h0001;
    end
  end
  // state registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= UFA_IDLE;
      div_q <= 16'h0000;
      slice_q <= 4'h0;
      votes_q <= 2'h0;
      bitno_q <= 4'h0;
      shift_q <= 9'h000;
      prev_q <= 1'b1;
      done_q <= 1'b0;
      data_q <= 8'h00;
      ninth_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      state_q <= state_d;
      div_q <= div_d;
      slice_q <= slice_d;
      votes_q <= votes_d;
      bitno_q <= bitno_d;
      shift_q <= shift_d;
      prev_q <= prev_d;
      done_q <= done_d;
      data_q <= data_d;
      ninth_q <= ninth_d;
      stop_q <= stop_d;
    end
  end
  assign o_done = done_q;
  assign o_data = data_q;
  assign o_ninth = ninth_q;
  assign o_stop = stop_q;
endmodule

// >>> rtl/ufa_top.sv
// serial receive extension: framing error flag and address recognition
// register map by word index; the byte address is four times it
//   0x98 serial control: b7 mode high bit or error flag, b6 mode low
//        bit, b5 address filter on, b4 receive enable, b3 ninth bit to
//        send, b2 received tag bit, b1 send flag, b0 frame done flag
//   0x99 received byte, read only
//   0x87 power control: b6 picks which home bit 7 reaches
//   0xA9 slave address, 0xB9 slave address mask
//   0xC0 event status, write one to clear: b0 frame taken, b1 bad stop
//   0xC1 event mask, same layout as the status word
//   0xC2 tick divider: a sixteenth-bit tick every divider+1 clocks
//
// modes by {b6, b7}: 00 not received here, 01 eight data bits with
// the stop bit as tag, 10 and 11 nine data bits with the ninth as tag
//
// receive walk: a falling edge restarts the slice count; the start
// bit is voted mid bit and a one there drops the attempt; data bits
// follow least significant first, then the ninth bit in nine-bit
// modes, then the stop bit; at the stop vote the frame is offered to
// the acceptance logic for one cycle and hunting starts again
//
// hazards and limits
//   a read whose address phase meets a write's data phase returns
//   the old value; leave one idle cycle between them
//   a hardware set beats a software clear on the same edge
//   writing one to the done or error flag never sets it
//   the transfer size is ignored; only whole words are expected
//   changing the divider during a frame corrupts that frame
`timescale 1ns/1ns
module ufa_top
  import ufa_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic i_rxd,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_irq
);
  // serial control storage; bit 7 has two homes
  logic mode_hi_q, mode_hi_d; // mode_select_high_bit
  logic fe_q, fe_d; // framing_error_flag
  logic [6:0] serial_control_reg_q, serial_control_reg_d; // remaining control bits
  logic [7:0] power_control_reg_q, power_control_reg_d; // power_control_reg
  // address filter registers
  logic [7:0] slave_address_q, slave_address_d; // slave_address
  logic [7:0] slave_address_mask_q, slave_address_mask_d; // slave_address_mask
  logic [7:0] rbuf_q, rbuf_d; // received byte
  logic [15:0] baud_q, baud_d; // 16x tick divider value
  // event status and mask
  logic [IRQ_W-1:0] ist_q, ist_d; // sticky event bits
  logic [IRQ_W-1:0] imask_q, imask_d; // event enables
  // interrupt line register
  logic irq_q, irq_d;
  // bus state
  logic wr_pend_q, wr_pend_d; // write data phase due
  logic [7:0] wr_idx_q, wr_idx_d; // index for that write
  logic [31:0] hrdata_q, hrdata_d;
  logic hreadyout_q;
  logic hresp_q; // response, always okay
  // receiver results
  logic rx_done;
  logic [7:0] rx_data;
  logic rx_ninth;
  logic rx_stop;
  logic addr_match;
  // decoded helpers
  logic view_err; // error_flag_view_select
  logic nine_bit; // modes 2 and 3
  logic rx_en;
  logic mp_en; // multiprocessor_enable
  logic tag_bit; // ninth bit or stop bit
  logic accept;
  logic bad_stop;
  logic addr_phase;
  logic wr_serial_control_reg;

  // index of a word address
  // the two low byte bits are dropped; only aligned words are used
  function automatic logic [7:0] word_idx(input logic [31:0] a);
    return a[9:2];
  endfunction

  // read value of one register index
  function automatic logic [31:0] read_word(input logic [7:0] idx,
                                            input logic view);
    logic [31:0] v;
    v = WORD_ZERO;
    // bits above a register's width read as zero
    case (idx)
      SERIAL_CONTROL_IDX: begin
        v[7:0] = {view ? fe_q : mode_hi_q, serial_control_reg_q};
      end
      RX_BUFFER_IDX: v[7:0] = rbuf_q;
      POWER_CONTROL_IDX: v[7:0] = power_control_reg_q;
      SLAVE_ADDRESS_IDX: v[7:0] = slave_address_q;
      SLAVE_ADDRESS_MASK_IDX: v[7:0] = slave_address_mask_q;
      IRQ_STATUS_IDX: v[IRQ_W-1:0] = ist_q;
      IRQ_MASK_IDX: v[IRQ_W-1:0] = imask_q;
      BAUD_DIV_IDX: v[15:0] = baud_q;
      default: v = WORD_ZERO; // unmapped reads as zero
    endcase
    return v;
  endfunction

  // address recognition over the received byte
  // both the given and the broadcast test run on every frame
  ufa_match u_match (
    .i_byte(rx_data),
    .i_addr(slave_address_q),
    .i_mask(slave_address_mask_q),
    .o_match(addr_match)
  );

  // bit sampler and frame assembler
  // it hunts for a falling edge, votes three slices mid bit and
  // hands over each frame with a one-cycle done pulse
  ufa_rx u_rx (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_enable(rx_en),
    .i_nine(nine_bit),
    .i_div(baud_q),
    .i_rxd(i_rxd),
    .o_done(rx_done),
    .o_data(rx_data),
    .o_ninth(rx_ninth),
    .o_stop(rx_stop)
  );

  // mode decode and frame acceptance
  always_comb begin
    // which home bit 7 of serial control reaches
    view_err = power_control_reg_q[PC_VIEW];
    nine_bit = serial_control_reg_q[SC_MODE_LO];
    mp_en = serial_control_reg_q[SC_MP_EN];
    // mode 0 is synchronous and not received here
    rx_en = serial_control_reg_q[SC_RX_EN] & (mode_hi_q | nine_bit);
    // mode 1 tests the stop bit, modes 2/3 the ninth bit
    tag_bit = nine_bit ? rx_ninth : rx_stop;
    // done must be clear; with the filter on, tag and match too
    accept = rx_done & ~serial_control_reg_q[SC_RX_DONE]
           & (~mp_en | (tag_bit & addr_match));
    // a bad stop counts even when the frame is dropped
    bad_stop = rx_done & ~rx_stop;
    // an address phase counts only while the bus is ready
    addr_phase = i_hsel & i_htrans[HTRANS_ACTIVE] & i_hready;
    // a serial control write in its data phase
    wr_serial_control_reg = wr_pend_q & (wr_idx_q == SERIAL_CONTROL_IDX);
  end

  // bus phases and register next values
  // an address phase is taken at one edge; read data is loaded then
  // and stands for the data phase; a write lands at the next edge,
  // taking the write bus of that data phase; no wait states
  always_comb begin
    mode_hi_d = mode_hi_q;
    fe_d = fe_q;
    serial_control_reg_d = serial_control_reg_q;
    power_control_reg_d = power_control_reg_q;
    slave_address_d = slave_address_q;
    slave_address_mask_d = slave_address_mask_q;
    rbuf_d = rbuf_q;
    baud_d = baud_q;
    ist_d = ist_q;
    imask_d = imask_q;
    // a write data phase lasts one cycle only
    wr_pend_d = 1'b0;
    wr_idx_d = wr_idx_q;
    hrdata_d = hrdata_q;
    // address phase: latch write target, fetch read data
    if (addr_phase) begin
      wr_pend_d = i_hwrite;
      wr_idx_d = word_idx(i_haddr);
      if (!i_hwrite) begin
        hrdata_d = read_word(word_idx(i_haddr), view_err);
      end
    end
    // data phase of a write
    if (wr_pend_q) begin
      case (wr_idx_q)
        SERIAL_CONTROL_IDX: begin
          // bit 7 reaches the error flag or the mode bit, not both
          serial_control_reg_d = i_hwdata[6:0];
          if (view_err) begin
            // error bit can only be cleared by software
            if (!i_hwdata[SC_MODE_HI]) begin
              fe_d = 1'b0;
            end
          end else begin
            mode_hi_d = i_hwdata[SC_MODE_HI];
          end
        end
        POWER_CONTROL_IDX: power_control_reg_d = i_hwdata[7:0];
        SLAVE_ADDRESS_IDX: slave_address_d = i_hwdata[7:0];
        SLAVE_ADDRESS_MASK_IDX: slave_address_mask_d = i_hwdata[7:0];
        IRQ_STATUS_IDX: ist_d = ist_q & ~i_hwdata[IRQ_W-1:0];
        IRQ_MASK_IDX: imask_d = i_hwdata[IRQ_W-1:0];
        BAUD_DIV_IDX: baud_d = i_hwdata[15:0];
        // the received byte word is read only and lands here too
        default: ; // unmapped writes are ignored
      endcase
    end
    // hardware updates win over a same-cycle software write
    if (accept) begin
      // byte, tag bit and done flag load together
      rbuf_d = rx_data;
      serial_control_reg_d[SC_RX_NINTH] = tag_bit;
      serial_control_reg_d[SC_RX_DONE] = 1'b1;
      ist_d[IRQ_RX] = 1'b1;
    end else if (wr_serial_control_reg) begin
      // a write cannot raise the complete flag by itself
      serial_control_reg_d[SC_RX_DONE] = i_hwdata[SC_RX_DONE] & serial_control_reg_q[SC_RX_DONE];
    end
    // later good frames leave the error flag alone
    if (bad_stop) begin
      fe_d = 1'b1;
      ist_d[IRQ_FE] = 1'b1;
    end
  end

  // interrupt level from unmasked sticky bits
  // taken from next values so the line moves with the status
  always_comb begin
    irq_d = |(ist_d & imask_d);
  end

  // register file
  // every register clears on reset except the tick divider
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mode_hi_q <= 1'b0;
      fe_q <= 1'b0;
      serial_control_reg_q <= 7'h00;
      power_control_reg_q <= BYTE_RST;
      slave_address_q <= BYTE_RST;
      slave_address_mask_q <= BYTE_RST;
      rbuf_q <= BYTE_RST;
      baud_q <= BAUD_DIV_RST;
      ist_q <= '0;
      imask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      mode_hi_q <= mode_hi_d;
      fe_q <= fe_d;
      serial_control_reg_q <= serial_control_reg_d;
      power_control_reg_q <= power_control_reg_d;
      slave_address_q <= slave_address_d;
      slave_address_mask_q <= slave_address_mask_d;
      rbuf_q <= rbuf_d;
      baud_q <= baud_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      irq_q <= irq_d;
    end
  end

  // bus registers; slave never inserts wait states
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
      hrdata_q <= WORD_ZERO;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_idx_q <= wr_idx_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  // every output leaves a flip-flop
  assign o_hrdata = hrdata_q;
  assign o_hreadyout = hreadyout_q;
  assign o_hresp = hresp_q;
  assign o_irq = irq_q;
endmodule

// >>> verif/ufa_chk.sv
// port-level checks for the frame error and address match block
`timescale 1ns/1ns
module ufa_chk
  import ufa_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic take; // address phase taken at this edge
  logic [7:0] idx; // word index of the address phase
  logic is_sa; // address phase names an address register
  logic sa_wr_q; // an address register written since reset
  logic sa_wr_d;
  assign take = i_hsel & i_htrans[HTRANS_ACTIVE] & i_hready;
  assign idx = i_haddr[9:2];
  assign is_sa = (idx == SLAVE_ADDRESS_IDX)
    || (idx == SLAVE_ADDRESS_MASK_IDX);
  // remember a write to the address registers
  always_comb begin
    sa_wr_d = sa_wr_q;
    if (take && i_hwrite && is_sa) begin
      sa_wr_d = 1'b1;
    end
  end
  // register the write memory
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sa_wr_q <= 1'b0;
    end else begin
      sa_wr_q <= sa_wr_d;
    end
  end
  // a read address phase, then a mask write with zero data
  sequence s_rd;
    take && !i_hwrite;
  endsequence
  sequence s_mask_clr;
    (take && i_hwrite && idx == IRQ_MASK_IDX) ##1 (i_hwdata == WORD_ZERO);
  endsequence
  property p_ready;
    o_hreadyout == 1'b1;
  endproperty
  property p_okay;
    o_hresp == 1'b0;
  endproperty
  property p_hold;
    !(take && !i_hwrite) |=> $stable(o_hrdata);
  endproperty
  property p_addr_rst;
    s_rd and (is_sa && !sa_wr_q) |=> o_hrdata == WORD_ZERO;
  endproperty
  property p_addr_width;
    s_rd and is_sa |=> o_hrdata[31:8] == 24'h000000;
  endproperty
  property p_unmapped;
    s_rd and (idx == 8'h10) |=> o_hrdata == WORD_ZERO;
  endproperty
  property p_mask_off;
    s_mask_clr |=> ##1 !o_irq;
  endproperty
  property p_irq_sticky;
    $fell(o_irq) |-> $past(take && i_hwrite, 2);
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready dropped");
  a_okay: assert property (p_okay)
    else $error("error response seen");
  a_hold: assert property (p_hold)
    else $error("read data changed without a read");
  a_addr_rst: assert property (p_addr_rst)
    else $error("address register not zero after reset");
  a_addr_width: assert property (p_addr_width)
    else $error("address register upper bits set");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_mask_off: assert property (p_mask_off)
    else $error("interrupt high with mask clear");
  a_irq_sticky: assert property (p_irq_sticky)
    else $error("interrupt fell without a write");
endmodule

bind ufa_top ufa_chk chk_u (.i_clk(i_clk), .i_reset(i_reset),
  .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
  .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_irq(o_irq));

// >>> verif/ufa_line_src.sv
// serial line source standing in for the remote controller
`timescale 1ns/1ns
module ufa_line_src (
  input wire logic i_clk,
  output logic o_rxd
);
  int bit_clks = 32; // clocks per bit at divider one
  initial o_rxd = 1'b1;
  // start, data lsb first, ninth in 9-bit modes, stop, idle
  task automatic send(input logic [7:0] d, input logic nine,
    input logic ninth, input logic stop);
    logic [9:0] f;
    f = nine ? {stop, ninth, d} : {1'b1, stop, d};
    f = {f[8:0], 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(posedge i_clk);
      o_rxd <= (i == 10) ? stop : f[i];
      repeat (bit_clks - 1) @(posedge i_clk);
    end
    @(posedge i_clk);
    o_rxd <= 1'b1;
    repeat (bit_clks) @(posedge i_clk);
  endtask
endmodule

// >>> verif/tb_ufa_top.sv
// bench: register accesses and serial frames through the receive block
`timescale 1ns/1ns
module tb_ufa_top;
  import ufa_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_hsel = 1'b0;
  logic [31:0] i_haddr = WORD_ZERO;
  logic [1:0] i_htrans = 2'h0;
  logic i_hwrite = 1'b0;
  logic [31:0] i_hwdata = WORD_ZERO;
  logic i_rxd;
  logic [31:0] o_hrdata;
  logic o_hreadyout;
  logic o_hresp;
  logic o_irq;
  int errors = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic [7:0] fb [4] = '{8'hA1, 8'hA6, 8'hFF, 8'hA0};
  logic fn [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  logic fa [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  always #10 i_clk = ~i_clk;
  ufa_top dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .i_rxd(i_rxd), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .o_irq(o_irq));
  ufa_line_src src (.i_clk(i_clk), .o_rxd(i_rxd));
  // one single word: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] x,
    input logic [31:0] d);
    @(posedge i_clk);
    i_hsel <= 1'b1;
    i_haddr <= {22'h0, x, 2'h0};
    i_htrans <= 2'h2;
    i_hwrite <= w;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
  endtask
  // read a register and compare the masked bits
  task automatic rc(input logic [7:0] x, input logic [31:0] m,
    input logic [31:0] e);
    xfer(1'b0, x, WORD_ZERO);
    samples_checked++;
    if ((rd & m) !== e) begin
      errors++;
      $display("CHECK FAILED %0t reg %h got %h exp %h", $time, x, rd, e);
    end
  endtask
  // compare the interrupt line once it has settled
  task automatic ci(input logic e);
    repeat (2) @(posedge i_clk);
    samples_checked++;
    if (o_irq !== e) begin
      errors++;
      $display("CHECK FAILED %0t irq got %b", $time, o_irq);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // cut a hang short
  initial begin
    repeat (40000) @(posedge i_clk);
    errors++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    rc(SLAVE_ADDRESS_IDX, 32'hFFFF_FFFF, WORD_ZERO);
    rc(SLAVE_ADDRESS_MASK_IDX, 32'hFFFF_FFFF, WORD_ZERO);
    rc(8'h10, 32'hFFFF_FFFF, WORD_ZERO);
    $display("test reset done");
    xfer(1'b1, BAUD_DIV_IDX, 32'h1);
    xfer(1'b1, IRQ_MASK_IDX, 32'h1);
    // mode 2 without filter, then a frame while complete is pending
    xfer(1'b1, SERIAL_CONTROL_IDX, 32'h50);
    src.send(8'h5A, 1'b1, 1'b1, 1'b1);
    rc(RX_BUFFER_IDX, 32'hFF, 32'h5A);
    rc(SERIAL_CONTROL_IDX, 32'hFF, 32'h55);
    ci(1'b1);
    src.send(8'hC3, 1'b1, 1'b0, 1'b1);
    rc(RX_BUFFER_IDX, 32'hFF, 32'h5A);
    rc(SERIAL_CONTROL_IDX, 32'hFF, 32'h55);
    xfer(1'b1, IRQ_STATUS_IDX, 32'h3);
    ci(1'b0);
    $display("test plain done");
    // mode 3 filter: given hit, miss, broadcast hit, data byte
    xfer(1'b1, SLAVE_ADDRESS_IDX, 32'hA4);
    xfer(1'b1, SLAVE_ADDRESS_MASK_IDX, 32'hFA);
    rc(SLAVE_ADDRESS_MASK_IDX, 32'hFFFF_FFFF, 32'hFA);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, SERIAL_CONTROL_IDX, 32'hF0);
      src.send(fb[k], 1'b1, fn[k], 1'b1);
      rc(SERIAL_CONTROL_IDX, 32'h1, {31'h0, fa[k]});
    end
    $display("test filter done");
    // framing error, its view and its stickiness
    xfer(1'b1, SERIAL_CONTROL_IDX, 32'h50);
    src.send(8'h11, 1'b1, 1'b0, 1'b0);
    rc(SERIAL_CONTROL_IDX, 32'h80, WORD_ZERO);
    rc(IRQ_STATUS_IDX, 32'h2, 32'h2);
    xfer(1'b1, POWER_CONTROL_IDX, 32'h40);
    rc(SERIAL_CONTROL_IDX, 32'h80, 32'h80);
    xfer(1'b1, POWER_CONTROL_IDX, WORD_ZERO);
    xfer(1'b1, SERIAL_CONTROL_IDX, 32'h50);
    src.send(8'h22, 1'b1, 1'b0, 1'b1);
    xfer(1'b1, POWER_CONTROL_IDX, 32'h40);
    rc(SERIAL_CONTROL_IDX, 32'h81, 32'h81);
    xfer(1'b1, SERIAL_CONTROL_IDX, 32'h50);
    rc(SERIAL_CONTROL_IDX, 32'h80, WORD_ZERO);
    xfer(1'b1, POWER_CONTROL_IDX, WORD_ZERO);
    $display("test framing done");
    // mode 1 filter: valid stop and match, then a bad stop
    xfer(1'b1, SERIAL_CONTROL_IDX, 32'hB0);
    src.send(8'hA0, 1'b0, 1'b0, 1'b1);
    rc(SERIAL_CONTROL_IDX, 32'h1, 32'h1);
    rc(RX_BUFFER_IDX, 32'hFF, 32'hA0);
    rc(SERIAL_CONTROL_IDX, 32'h80, 32'h80);
    xfer(1'b1, SERIAL_CONTROL_IDX, 32'hB0);
    src.send(8'hA0, 1'b0, 1'b0, 1'b0);
    rc(SERIAL_CONTROL_IDX, 32'h1, WORD_ZERO);
    $display("test mode1 done");
    // interrupt masked, unmasked, cleared
    ci(1'b1);
    xfer(1'b1, IRQ_MASK_IDX, WORD_ZERO);
    ci(1'b0);
    xfer(1'b1, IRQ_MASK_IDX, 32'h3);
    ci(1'b1);
    xfer(1'b1, IRQ_STATUS_IDX, 32'h3);
    ci(1'b0);
    $display("test irq done");
    wrap_up();
  end
endmodule
